// ### logic/interp_chain_nco_modulator.sv
// Interpolation chain with premodulation, three half-band stages and carrier mixer
`timescale 1ns/100ps
module interp_chain_nco_modulator
    import interp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic     clk,
    input  wire logic     rstn,
    input  wire logic     in_valid,
    output logic          in_ready,
    input  wire iq_t      in_sample,
    output logic          out_valid_r,
    input  wire logic     out_ready,
    output iq_t           out_sample_r,
    input  wire cfg_req_t cfg,
    output logic [7:0]    cfg_rdata_r
);

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------

    // Clamp a wide value into the sample range
    function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [35:0] v);
        logic signed [35:0] hi;
        logic signed [35:0] lo;
        hi = 36'sd32767;
        lo = -36'sd32768;
        if (v > hi) begin
            sat = 16'sh7fff;
        end else if (v < lo) begin
            sat = 16'sh8000;
        end else begin
            sat = v[SAMPLE_W-1:0];
        end
    endfunction : sat

    // Complex multiply of a sample by a Q15 rotation pair
    function automatic iq_t cmul(input iq_t x, input coef_t k);
        logic signed [35:0] a;
        logic signed [35:0] b;
        a = x.i * k.c - x.q * k.s;
        b = x.i * k.s + x.q * k.c;
        cmul.i = sat(a >>> Q15_SHIFT);
        cmul.q = sat(b >>> Q15_SHIFT);
    endfunction : cmul

    // Rotation by k eighths of a turn
    function automatic coef_t rot(input logic [2:0] k);
        unique case (k)
            3'h0: rot = '{c: Q15_ONE,    s: 18'sh0};
            3'h1: rot = '{c: Q15_HALF2,  s: Q15_HALF2};
            3'h2: rot = '{c: 18'sh0,     s: Q15_ONE};
            3'h3: rot = '{c: -Q15_HALF2, s: Q15_HALF2};
            3'h4: rot = '{c: -Q15_ONE,   s: 18'sh0};
            3'h5: rot = '{c: -Q15_HALF2, s: -Q15_HALF2};
            3'h6: rot = '{c: 18'sh0,     s: -Q15_ONE};
            3'h7: rot = '{c: Q15_HALF2,  s: -Q15_HALF2};
        endcase
    endfunction : rot

    // Quarter-wave sine magnitude, n in 0..16 sixteenths of a quarter turn
    function automatic logic signed [17:0] qsin(input logic [4:0] n);
        unique case (n)
            5'h00: qsin = 18'sd0;
            5'h01: qsin = 18'sd3212;
            5'h02: qsin = 18'sd6393;
            5'h03: qsin = 18'sd9512;
            5'h04: qsin = 18'sd12539;
            5'h05: qsin = 18'sd15446;
            5'h06: qsin = 18'sd18204;
            5'h07: qsin = 18'sd20787;
            5'h08: qsin = 18'sd23170;
            5'h09: qsin = 18'sd25329;
            5'h0a: qsin = 18'sd27245;
            5'h0b: qsin = 18'sd28898;
            5'h0c: qsin = 18'sd30273;
            5'h0d: qsin = 18'sd31356;
            5'h0e: qsin = 18'sd32137;
            5'h0f: qsin = 18'sd32609;
            default: qsin = Q15_ONE;  // Peak is exactly one so quarter turns stay exact
        endcase
    endfunction : qsin

    // Full-cycle sine from the top phase bits
    function automatic logic signed [17:0] sine(input logic [NCO_LUT_W-1:0] p);
        logic [4:0]         j;
        logic signed [17:0] m;
        j = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
        m = qsin(j);
        sine = p[5] ? -m : m;
    endfunction : sine

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0]  path_ctrl_r;
    logic [7:0]  stage_mode_r [3];
    logic [31:0] tune_pend_r;
    logic [31:0] tune_act_r;
    logic [7:0]  tune_upd_r;
    logic        upd_rise;

    // Rising edge of the update bit, seen against the value it replaces
    assign upd_rise = cfg.we && (cfg.addr == TUNE_UPDATE_OFS)
                      && cfg.wdata[TUNE_UPDATE_BIT] && !tune_upd_r[TUNE_UPDATE_BIT];

    // Register writes; every field but the tuning word acts at once
    always_ff @(posedge clk) begin
        if (!rstn) begin
            path_ctrl_r     <= PATH_CTRL_RST;
            stage_mode_r[0] <= MODE_RST;
            stage_mode_r[1] <= MODE_RST;
            stage_mode_r[2] <= MODE_RST;
            tune_pend_r     <= TUNE_WORD_RST;
            tune_upd_r      <= TUNE_UPDATE_RST;
        end else if (cfg.we) begin
            unique case (cfg.addr)
                PATH_CTRL_OFS:   path_ctrl_r     <= cfg.wdata;
                STAGE1_MODE_OFS: stage_mode_r[0] <= cfg.wdata;
                STAGE2_MODE_OFS: stage_mode_r[1] <= cfg.wdata;
                STAGE3_MODE_OFS: stage_mode_r[2] <= cfg.wdata;
                TUNE_BYTE0_OFS:  tune_pend_r[7:0]   <= cfg.wdata;
                TUNE_BYTE1_OFS:  tune_pend_r[15:8]  <= cfg.wdata;
                TUNE_BYTE2_OFS:  tune_pend_r[23:16] <= cfg.wdata;
                TUNE_BYTE3_OFS:  tune_pend_r[31:24] <= cfg.wdata;
                TUNE_UPDATE_OFS: tune_upd_r      <= cfg.wdata;
                default: ;
            endcase
        end
    end

    // Pending tuning word moves to the oscillator only on the update edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tune_act_r <= TUNE_WORD_RST;
        end else if (upd_rise) begin
            tune_act_r <= tune_pend_r;
        end
    end

    // Register readback, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_rdata_r <= 8'h00;
        end else if (cfg.re) begin
            unique case (cfg.addr)
                PATH_CTRL_OFS:   cfg_rdata_r <= path_ctrl_r;
                STAGE1_MODE_OFS: cfg_rdata_r <= stage_mode_r[0];
                STAGE2_MODE_OFS: cfg_rdata_r <= stage_mode_r[1];
                STAGE3_MODE_OFS: cfg_rdata_r <= stage_mode_r[2];
                TUNE_BYTE0_OFS:  cfg_rdata_r <= tune_pend_r[7:0];
                TUNE_BYTE1_OFS:  cfg_rdata_r <= tune_pend_r[15:8];
                TUNE_BYTE2_OFS:  cfg_rdata_r <= tune_pend_r[23:16];
                TUNE_BYTE3_OFS:  cfg_rdata_r <= tune_pend_r[31:24];
                TUNE_UPDATE_OFS: cfg_rdata_r <= tune_upd_r;
                default:         cfg_rdata_r <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Input FIFO and premodulation
    // ------------------------------------------------------------------
    // Chain nodes: 0 premod out, 1 stage one out, 2 mixer out,
    // 3 stage two out, 4 stage three out
    logic ch_v [5];
    logic ch_r [5];
    iq_t  ch_d [5];
    iq_t  fifo_d;
    logic [2:0] pm_ph_r;

    sample_fifo #(
        .WIDTH ($bits(iq_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .rstn    (rstn),
        .s_valid (in_valid),
        .s_ready (in_ready),
        .s_data  (in_sample),
        .m_valid (ch_v[0]),
        .m_ready (ch_r[0]),
        .m_data  (fifo_d)
    );

    // Alternate sign per sample: shift up by half the data rate
    assign ch_d[0] = path_ctrl_r[PREMOD_EN_BIT] ? cmul(fifo_d, rot(pm_ph_r)) : fifo_d;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pm_ph_r <= 3'h0;
        end else if (ch_v[0] && ch_r[0]) begin
            pm_ph_r <= pm_ph_r + STEP_HALF_TURN;
        end
    end

    // ------------------------------------------------------------------
    // Half-band stages
    // ------------------------------------------------------------------
    // Each mode is a baseband half-band filter with the input rotated
    // down to its centre and the doubled-rate output rotated back up.
    // Whole-turn input shifts vanish at the input rate, so modulated
    // modes reuse the rotation of their unmodulated twin.
    for (genvar g = 0; g < 3; g++) begin : g_stage
        localparam int IX = (g == 0) ? 0 : g + 1;

        logic       byp;
        logic [2:0] in_step;
        logic [2:0] out_step;
        iq_t        xr;
        iq_t        line_r [3];
        iq_t        even_r;
        iq_t        odd_r;
        logic       have_r;
        logic       ph_r;
        logic [2:0] iph_r;
        logic [2:0] oph_r;
        logic       take;
        logic       give;
        iq_t        ys;

        assign byp = path_ctrl_r[STAGE_BYP_LSB + g];

        // Rotation steps per sample, in eighths of a turn
        if (g == 0) begin : g_first
            assign in_step  = {stage_mode_r[0][0], 2'b00};
            assign out_step = {stage_mode_r[0][1:0], 1'b0};
        end else begin : g_later
            assign in_step  = 3'(3'h0 - {stage_mode_r[g][1:0], 1'b0});
            assign out_step = stage_mode_r[g][2:0];
        end

        assign take = ch_v[IX] && ch_r[IX] && !byp;
        assign give = ch_v[IX+1] && ch_r[IX+1] && !byp;
        assign xr   = cmul(ch_d[IX], rot(iph_r));
        assign ys   = cmul(ph_r ? odd_r : even_r, rot(oph_r));

        // Bypass passes samples straight through; otherwise two out per one
        assign ch_r[IX]    = byp ? ch_r[IX+1] : (!have_r || (ph_r && ch_r[IX+1]));
        assign ch_v[IX+1]  = byp ? ch_v[IX] : have_r;
        assign ch_d[IX+1]  = byp ? ch_d[IX] : ys;

        // Delay line and the two output phases; one shape for every mode
        always_ff @(posedge clk) begin
            if (!rstn) begin
                line_r[0] <= '0;
                line_r[1] <= '0;
                line_r[2] <= '0;
                even_r    <= '0;
                odd_r     <= '0;
            end else if (take) begin
                line_r[0] <= xr;
                line_r[1] <= line_r[0];
                line_r[2] <= line_r[1];
                even_r    <= line_r[1];
                odd_r.i   <= sat((36'(line_r[1].i) + 36'(line_r[0].i)) * 36'sd9
                                 - 36'(xr.i) - 36'(line_r[2].i) >>> 4);
                odd_r.q   <= sat((36'(line_r[1].q) + 36'(line_r[0].q)) * 36'sd9
                                 - 36'(xr.q) - 36'(line_r[2].q) >>> 4);
            end
        end

        // Output sequencing: even sample then odd sample
        always_ff @(posedge clk) begin
            if (!rstn) begin
                have_r <= 1'b0;
                ph_r   <= 1'b0;
            end else if (take) begin
                have_r <= 1'b1;
                ph_r   <= 1'b0;
            end else if (give && ph_r) begin
                have_r <= 1'b0;
            end else if (give) begin
                ph_r   <= 1'b1;
            end
        end

        // Input and output rotation phases
        always_ff @(posedge clk) begin
            if (!rstn) begin
                iph_r <= 3'h0;
                oph_r <= 3'h0;
            end else begin
                if (take) begin
                    iph_r <= iph_r + in_step;
                end
                if (give) begin
                    oph_r <= oph_r + out_step;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Carrier oscillator and quadrature mixer
    // ------------------------------------------------------------------
    // Sits after stage one, so it steps at the data rate or twice it
    logic [31:0] acc_r;
    logic        mix_v_r;
    iq_t         mix_d_r;
    coef_t       carrier;
    logic        mix_take;

    assign mix_take  = ch_v[1] && ch_r[1];
    assign ch_r[1]   = !mix_v_r || ch_r[2];
    assign ch_v[2]   = mix_v_r;
    assign ch_d[2]   = mix_d_r;
    assign carrier.c = sine(NCO_LUT_W'(acc_r[31 -: NCO_LUT_W] + 6'h10));
    assign carrier.s = sine(acc_r[31 -: NCO_LUT_W]);

    // Phase accumulator advances once per sample leaving stage one
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_r <= 32'h0000_0000;
        end else if (mix_take) begin
            acc_r <= acc_r + tune_act_r;
        end
    end

    // Mix with cos/sin and sum cross products into I and Q
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mix_v_r <= 1'b0;
            mix_d_r <= '0;
        end else if (ch_r[1]) begin
            mix_v_r <= ch_v[1];
            if (mix_take) begin
                mix_d_r <= path_ctrl_r[NCO_EN_BIT] ? cmul(ch_d[1], carrier) : ch_d[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------------
    assign ch_r[4] = !out_valid_r || out_ready;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_valid_r  <= 1'b0;
            out_sample_r <= '0;
        end else if (ch_r[4]) begin
            out_valid_r <= ch_v[4];
            if (ch_v[4]) begin
                out_sample_r <= ch_d[4];
            end
        end
    end

endmodule : interp_chain_nco_modulator

// ### include/interp_pkg.sv
// Shared types, register map and constants for the interpolation and carrier datapath
package interp_pkg;

    // ------------------------------------------------------------------
    // Sample carrier
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 16;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] i;
        logic signed [SAMPLE_W-1:0] q;
    } iq_t;

    // Rotation coefficient pair in Q15 with headroom for +1.0
    typedef struct packed {
        logic signed [17:0] c;
        logic signed [17:0] s;
    } coef_t;

    // Register write/read request
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PATH_CTRL_OFS    = 8'h1b;
    localparam logic [7:0] STAGE1_MODE_OFS  = 8'h1c;
    localparam logic [7:0] STAGE2_MODE_OFS  = 8'h1d;
    localparam logic [7:0] STAGE3_MODE_OFS  = 8'h1e;
    localparam logic [7:0] TUNE_BYTE0_OFS   = 8'h30;
    localparam logic [7:0] TUNE_BYTE1_OFS   = 8'h31;
    localparam logic [7:0] TUNE_BYTE2_OFS   = 8'h32;
    localparam logic [7:0] TUNE_BYTE3_OFS   = 8'h33;
    localparam logic [7:0] TUNE_UPDATE_OFS  = 8'h36;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PREMOD_EN_BIT   = 0;
    localparam int NCO_EN_BIT      = 1;
    localparam int STAGE_BYP_LSB   = 2;   // Bypass bits for stages 1..3
    localparam int TUNE_UPDATE_BIT = 0;

    localparam logic [7:0]  PATH_CTRL_RST   = 8'h00;
    localparam logic [7:0]  MODE_RST        = 8'h00;
    localparam logic [7:0]  TUNE_UPDATE_RST = 8'h00;
    localparam logic [31:0] TUNE_WORD_RST   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Fixed-point constants
    // ------------------------------------------------------------------
    localparam logic signed [17:0] Q15_ONE   = 18'sh08000;
    localparam logic signed [17:0] Q15_HALF2 = 18'sh05a82;  // cos 45 degrees
    localparam int                 Q15_SHIFT = 15;
    localparam int                 NCO_LUT_W = 6;           // Phase bits into sine table

    // Phase steps are counted in units of one eighth of a turn
    localparam logic [2:0] STEP_HALF_TURN = 3'h4;

endpackage : interp_pkg

// ### logic/sample_fifo.sv
// Sample FIFO with registered full flag and valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo
    import interp_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             s_valid,
    output logic                  s_ready,
    input  wire logic [WIDTH-1:0] s_data,
    output logic                  m_valid,
    input  wire logic             m_ready,
    output logic [WIDTH-1:0]      m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             ready_r;
    logic             push;
    logic             pop;

    // Handshakes; ready toward the source is the registered not-full flag
    assign push      = s_valid & ready_r;
    assign pop       = m_valid & m_ready;
    assign s_ready   = ready_r;
    assign m_valid   = (count_r != '0);
    assign m_data    = mem[rd_ptr_r];
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= s_data;
        end
    end

    // Pointers, level and full flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            ready_r <= (count_nxt != (AW+1)'(DEPTH));
        end
    end

endmodule : sample_fifo

// ### verif/interp_chain_nco_modulator_sva.sv
// Port-level checker for the interpolation and carrier datapath
`timescale 1ns/100ps
module interp_chain_nco_modulator_sva
    import interp_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire iq_t        in_sample,
    input wire logic       out_valid_r,
    input wire logic       out_ready,
    input wire iq_t        out_sample_r,
    input wire cfg_req_t   cfg,
    input wire logic [7:0] cfg_rdata_r
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_RESET_IDLE:
        assert property ($rose(rstn) |-> in_ready && !out_valid_r && cfg_rdata_r == 8'h00)
        else $error("outputs not idle after reset");
    AST_OUT_HOLD:
        assert property (out_valid_r && !out_ready |=> out_valid_r && $stable(out_sample_r))
        else $error("output sample dropped while stalled");
    AST_RDATA_HOLD:
        assert property (!cfg.re |=> $stable(cfg_rdata_r))
        else $error("read data changed without a read");
    AST_UNMAPPED_READ:
        assert property (cfg.re && !(cfg.addr inside {[8'h1b:8'h1e], [8'h30:8'h33], 8'h36})
                         |=> cfg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    AST_TUNE_READBACK:
        assert property ((cfg.we && cfg.addr inside {[8'h30:8'h33]}) ##1 !cfg.we ##1
                         (cfg.re && cfg.addr == $past(cfg.addr, 2))
                         |=> cfg_rdata_r == $past(cfg.wdata, 3))
        else $error("tuning byte readback wrong");
    AST_MODE_READBACK:
        assert property ((cfg.we && cfg.addr == 8'h1c) ##1 !cfg.we ##1
                         (cfg.re && cfg.addr == 8'h1c)
                         |=> cfg_rdata_r[1:0] == $past(cfg.wdata[1:0], 3))
        else $error("stage one mode readback wrong");
    AST_OUT_FOLLOWS_IN:
        assert property (in_valid && in_ready |-> ##[1:40] out_valid_r)
        else $error("taken sample never reached the output");
    AST_FULL_STALLED:
        assert property (!in_ready |-> out_valid_r)
        else $error("input refused while output idle");

    // Main scenarios reached
    COV_STALL: cover property (out_valid_r && !out_ready);
    COV_FULL:  cover property (!in_ready);
    COV_READ:  cover property (cfg.re);
endmodule : interp_chain_nco_modulator_sva

// ### verif/sample_source.sv
// Upstream sample source that holds each offered sample until it is taken
`timescale 1ns/100ps
module sample_source
    import interp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic in_ready,
    output logic      in_valid,
    output iq_t       in_sample
);
    iq_t pend[$];

    task push(input iq_t s);
        pend.push_back(s);
    endtask : push

    initial begin
        in_valid  = 1'b0;
        in_sample = '0;
    end

    // Offer the queue head; idle lines show the inverse of the last value
    always @(posedge clk) begin
        if (in_valid && in_ready)
            void'(pend.pop_front());
        if (rstn && pend.size() > 0) begin
            in_valid  <= 1'b1;
            in_sample <= pend[0];
        end else begin
            in_valid  <= 1'b0;
            in_sample <= ~in_sample;
        end
    end
endmodule : sample_source

// ### verif/interp_chain_nco_modulator_tb_top.sv
// Self-checking bench for the interpolation and carrier datapath
`timescale 1ns/100ps
module interp_chain_nco_modulator_tb_top
    import interp_pkg::*;
;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       in_valid, in_ready, out_valid_r;
    logic       out_ready = 1'b1;
    iq_t        in_sample, out_sample_r;
    cfg_req_t   cfg = '0;
    logic [7:0] cfg_rdata_r;
    iq_t        got[$];
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cyc = 0;

    always #5 clk = ~clk;

    interp_chain_nco_modulator #(.FIFO_DEPTH(16)) DUT (.clk(clk), .rstn(rstn),
        .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
        .out_valid_r(out_valid_r), .out_ready(out_ready), .out_sample_r(out_sample_r),
        .cfg(cfg), .cfg_rdata_r(cfg_rdata_r));
    sample_source src (.clk(clk), .rstn(rstn), .in_ready(in_ready),
        .in_valid(in_valid), .in_sample(in_sample));

    // Output sink and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (out_valid_r && out_ready)
            got.push_back(out_sample_r);
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task wr(input logic [7:0] a, input logic [7:0] d);
        cfg <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        cfg <= '0;
        @(posedge clk);
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        cfg <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        cfg <= '0;
        @(posedge clk);
        v = cfg_rdata_r;
    endtask : rd

    function automatic iq_t mk(input int i, input int q);
        mk.i = 16'(i);
        mk.q = 16'(q);
    endfunction : mk

    function automatic iq_t rot(input iq_t s, input int k);
        case (k % 4)
            0: rot = s;
            1: rot = '{i: -s.q, q: s.i};
            2: rot = '{i: -s.i, q: -s.q};
            default: rot = '{i: s.q, q: -s.i};
        endcase
    endfunction : rot

    task collect(input int n);
        for (int w = 0; w < 400 && got.size() < n; w++) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask : collect

    task push_n(input int n, input iq_t s);
        got.delete();
        for (int k = 0; k < n; k++) src.push(s);
    endtask : push_n

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs();
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            rd(TUNE_BYTE0_OFS + 8'(k), v);
            check("tune byte reset", v, TUNE_WORD_RST[8*k +: 8]);
            wr(TUNE_BYTE0_OFS + 8'(k), 8'(8'h11 * (k + 1)));
            rd(TUNE_BYTE0_OFS + 8'(k), v);
            check("tune byte", v, 8'(8'h11 * (k + 1)));
        end
        wr(STAGE1_MODE_OFS, 8'h03);
        rd(STAGE1_MODE_OFS, v);
        check("stage one mode", v[1:0], 2'h3);
        wr(STAGE1_MODE_OFS, MODE_RST);
        rd(8'h20, v);
        check("unmapped read", v, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task t_fifo();
        wr(PATH_CTRL_OFS, 8'h1c);
        out_ready <= 1'b0;
        got.delete();
        for (int k = 0; k < 24; k++) src.push(mk(k * 3 + 1, -k));
        for (int w = 0; w < 100 && in_ready; w++) @(posedge clk);
        check("fifo full", in_ready, 1'b0);
        out_ready <= 1'b1;
        collect(24);
        check("pass count", 32'(got.size()), 32'd24);
        for (int k = 0; k < 24; k++) check("pass sample", got[k], mk(k * 3 + 1, -k));
        $display("test fifo done");
    endtask : t_fifo

    task t_ratio();
        logic [7:0] byp [4] = '{8'h1c, 8'h18, 8'h10, 8'h00};
        for (int r = 0; r < 4; r++) begin
            wr(PATH_CTRL_OFS, byp[r]);
            push_n(4, mk(4096, 4096));
            collect(4 << r);
            check("ratio count", 32'(got.size()), 32'(4 << r));
        end
        $display("test ratio done");
    endtask : t_ratio

    task t_mode();
        logic [7:0] ctl [5] = '{8'h18, 8'h18, 8'h14, 8'h0c, 8'h1d};
        logic [7:0] reg_a [5] = '{8'h1c, 8'h1c, 8'h1d, 8'h1e, 8'h1c};
        logic [7:0] md [5] = '{8'h00, 8'h02, 8'h04, 8'h04, 8'h00};
        int         nout [5] = '{16, 16, 16, 16, 8};
        iq_t        dc;
        iq_t        ng;
        dc = mk(4096, 4096);
        ng = mk(-4096, -4096);
        for (int r = 0; r < 5; r++) begin
            wr(PATH_CTRL_OFS, ctl[r]);
            wr(reg_a[r], md[r]);
            push_n(8, dc);
            collect(nout[r]);
            check("mode count", 32'(got.size()), 32'(nout[r]));
            if (r == 0) begin
                check("mode even", got[14], dc);
                check("mode odd", got[15], dc);
            end else
                check("mode pair", (got[nout[r]-2] === dc && got[nout[r]-1] === ng) ||
                      (got[nout[r]-2] === ng && got[nout[r]-1] === dc), 1'b1);
            wr(reg_a[r], MODE_RST);
        end
        $display("test mode done");
    endtask : t_mode

    task nco_run(input int n, input int ph0, input int step);
        push_n(n, mk(291, -1110));
        collect(n);
        for (int k = 0; k < n; k++)
            check("carrier mix", got[k], rot(mk(291, -1110), ph0 + k * step));
    endtask : nco_run

    task t_nco();
        wr(PATH_CTRL_OFS, 8'h1e);
        nco_run(2, 0, 0);
        wr(TUNE_BYTE0_OFS, 8'h00);
        wr(TUNE_BYTE1_OFS, 8'h00);
        wr(TUNE_BYTE2_OFS, 8'h00);
        wr(TUNE_BYTE3_OFS, 8'h40);
        wr(TUNE_UPDATE_OFS, 8'h01);
        nco_run(4, 0, 1);
        wr(TUNE_BYTE3_OFS, 8'h80);
        wr(TUNE_UPDATE_OFS, 8'h01);
        nco_run(2, 0, 1);
        wr(TUNE_UPDATE_OFS, 8'h00);
        wr(TUNE_UPDATE_OFS, 8'h01);
        nco_run(2, 2, 2);
        wr(PATH_CTRL_OFS, 8'h1a);
        push_n(4, mk(291, -1110));
        collect(8);
        check("nco rate even", got[6], rot(mk(291, -1110), 2));
        check("nco rate odd", got[7], rot(mk(291, -1110), 0));
        $display("test nco done");
    endtask : t_nco

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_fifo();
        t_ratio();
        t_mode();
        t_nco();
        summarize();
    end
endmodule : interp_chain_nco_modulator_tb_top

bind interp_chain_nco_modulator interp_chain_nco_modulator_sva chk (.clk(clk), .rstn(rstn),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
    .out_valid_r(out_valid_r), .out_ready(out_ready), .out_sample_r(out_sample_r),
    .cfg(cfg), .cfg_rdata_r(cfg_rdata_r));
